// ===== src/smr_core_regs.sv
// Purpose: page pointer, mode control, stack pointers and stack push/pop engine
// Assumes: core register port, one clock, asynchronous active-low reset
// Notes:   external memory line drivers use active-low output enables
//
// Behaviour
// - page field bits 7:2 selects one of 64 sixteen-register pages for group F
// - page pointer bits 1:0 always read zero
// - selected page stays in force until software writes another
// - interrupt entry never pushes the page pointer
// - mode register resets to E0h
// - mode bit 7 places system stack in register file when set
// - mode bit 6 places user stack in register file when set
// - mode bit 5 halves the crystal clock when set
// - mode bits 4:2 set internal clock division from 1 to 8
// - mode bit 1 lets the bus request input through, else ignored
// - mode bit 0 floats external address, data and strobe lines
// - lines configured as general I/O ignore the float control
// - stack pointer predecrements on push, postincrements on pop
// - pop reads at the pointer and then moves it, stack contents untouched
// - system stack by default, user stack or word on request
// - interrupt pushes PC and flags, plus code segment if enabled
// - call pushes PC; segment call pushes PC and code segment
// - sixteen-bit pointers; register-file stacks use low byte only
// - 4 Mbyte space of 64 segments, each four 16-Kbyte pages
// - segment addresses beyond internal memory size are reserved
// - segment push enable lives in extended mode register two
`timescale 1ns/10ps
`default_nettype none

module smr_core_regs
  import smr_pkg::*;
#(
  parameter logic [16:0] INT_SEG_BYTES = 17'h10000
) (
  input  wire logic               clk_in,
  input  wire logic               nrst_in,
  input  wire smr_reg_req_t       reg_req_in,
  output logic [7:0]              reg_rd_data_out,
  output logic [5:0]              page_select_out,
  output logic                    paged_access_out,
  input  wire smr_stk_req_t       stk_req_in,
  input  wire logic               irq_entry_in,
  input  wire logic               call_in,
  input  wire logic               call_seg_in,
  input  wire logic [15:0]        pc_in,
  input  wire logic [7:0]         flags_in,
  input  wire logic [5:0]         code_seg_in,
  output logic                    stk_busy_out,
  output logic                    stk_wr_out,
  output logic                    stk_rd_out,
  output logic [15:0]             stk_addr_out,
  output logic [7:0]              stk_wr_data_out,
  output logic                    stk_in_regfile_out,
  output logic                    core_clk_en_out,
  input  wire logic               bus_request_pin_in,
  output logic                    bus_req_out,
  input  wire logic [7:0]         ext_line_in,
  input  wire logic [7:0]         ext_io_mode_in,
  input  wire logic [7:0]         ext_io_oe_n_in,
  output logic [7:0]              ext_line_out,
  output logic [7:0]              ext_line_oe_n_out,
  input  wire logic [2:0]         ext_ctrl_in,
  output logic [2:0]              ext_ctrl_out,
  output logic [2:0]              ext_ctrl_oe_n_out,
  input  wire logic [PHYS_W-1:0]  mem_addr_in,
  output logic [SEG_W-1:0]        mem_segment_out,
  output logic [PAGE_W-1:0]       mem_page_out,
  output logic                    mem_reserved_out
);

  // --------------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------------
  logic [7:0]  page_pointer_reg_ff;
  logic [7:0]  core_mode_reg_ff;
  logic [7:0]  ext_mode_reg_two_ff;
  logic [15:0] user_sp_ff;
  logic [15:0] sys_sp_ff;
  logic        ext_mode_reg_two_sel;
  logic        busy;

  assign ext_mode_reg_two_sel = (reg_req_in.addr == EXT_MODE_TWO_OFS) &&
                    (page_pointer_reg_ff[7:PAGE_FIELD_LSB] == EXT_MODE_TWO_PAGE);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      page_pointer_reg_ff <= 8'h00;
    end else if (reg_req_in.wr && reg_req_in.addr == PAGE_POINTER_OFS) begin
      page_pointer_reg_ff <= reg_req_in.wdata & PAGE_WR_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_mode_reg_ff <= CORE_MODE_RST;
    end else if (reg_req_in.wr && reg_req_in.addr == CORE_MODE_OFS) begin
      core_mode_reg_ff <= reg_req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_mode_reg_two_ff <= EXT_MODE_TWO_RST;
    end else if (reg_req_in.wr && ext_mode_reg_two_sel) begin
      ext_mode_reg_two_ff <= reg_req_in.wdata & EXT_MODE_TWO_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rd_data_out <= 8'h00;
    end else if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        PAGE_POINTER_OFS: reg_rd_data_out <= page_pointer_reg_ff;
        CORE_MODE_OFS:    reg_rd_data_out <= core_mode_reg_ff;
        USER_SP_HIGH_OFS: reg_rd_data_out <= user_sp_ff[15:8];
        USER_SP_LOW_OFS:  reg_rd_data_out <= user_sp_ff[7:0];
        SYS_SP_HIGH_OFS:  reg_rd_data_out <= sys_sp_ff[15:8];
        SYS_SP_LOW_OFS:   reg_rd_data_out <= sys_sp_ff[7:0];
        default:          reg_rd_data_out <= ext_mode_reg_two_sel ? ext_mode_reg_two_ff : 8'h00;
      endcase
    end
  end

  // page shown to the peripherals on every group F access
  assign page_select_out  = page_pointer_reg_ff[7:PAGE_FIELD_LSB];
  assign paged_access_out = (reg_req_in.wr || reg_req_in.rd) &&
                            (reg_req_in.addr[7:4] == TOP_GROUP);

  // --------------------------------------------------------------------------
  // clock division
  // --------------------------------------------------------------------------
  logic       half_tgl_ff;
  logic       osc_en;
  logic [2:0] presc_cnt_ff;
  logic [2:0] divider;

  assign divider = core_mode_reg_ff[DIVIDER_MSB:DIVIDER_LSB];
  assign osc_en  = core_mode_reg_ff[OSC_HALVING_BIT] ? half_tgl_ff : 1'b1;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      half_tgl_ff <= 1'b0;
    end else begin
      half_tgl_ff <= ~half_tgl_ff;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      presc_cnt_ff    <= 3'd0;
      core_clk_en_out <= 1'b0;
    end else begin
      core_clk_en_out <= osc_en && (presc_cnt_ff >= divider);
      if (osc_en) begin
        presc_cnt_ff <= (presc_cnt_ff >= divider) ? 3'd0 : presc_cnt_ff + 3'd1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // bus request and external line float
  // --------------------------------------------------------------------------
  logic bus_request_pin_s1_ff;
  logic bus_request_pin_s2_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_request_pin_s1_ff  <= 1'b0;
      bus_request_pin_s2_ff  <= 1'b0;
      bus_req_out <= 1'b0;
    end else begin
      bus_request_pin_s1_ff  <= bus_request_pin_in;
      bus_request_pin_s2_ff  <= bus_request_pin_s1_ff;
      bus_req_out <= bus_request_pin_s2_ff && core_mode_reg_ff[BUS_REQ_ALLOW_BIT];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_line
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          ext_line_out[gi]      <= 1'b0;
          ext_line_oe_n_out[gi] <= 1'b1;
        end else begin
          ext_line_out[gi]      <= ext_line_in[gi];
          ext_line_oe_n_out[gi] <= ext_io_mode_in[gi] ? ext_io_oe_n_in[gi]
                                 : core_mode_reg_ff[BUS_FLOAT_BIT];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_ctrl_out      <= 3'b000;
      ext_ctrl_oe_n_out <= 3'b111;
    end else begin
      ext_ctrl_out      <= ext_ctrl_in;
      ext_ctrl_oe_n_out <= {3{core_mode_reg_ff[BUS_FLOAT_BIT]}};
    end
  end

  // --------------------------------------------------------------------------
  // memory organisation
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_segment_out  <= '0;
      mem_page_out     <= '0;
      mem_reserved_out <= 1'b0;
    end else begin
      mem_segment_out  <= mem_addr_in[PHYS_W-1:OFFSET_W];
      mem_page_out     <= mem_addr_in[OFFSET_W-1:OFFSET_W-PAGE_W];
      mem_reserved_out <= {1'b0, mem_addr_in[OFFSET_W-1:0]} >= INT_SEG_BYTES;
    end
  end

  // --------------------------------------------------------------------------
  // stack engine
  // --------------------------------------------------------------------------
  smr_state_t  state_ff;
  smr_state_t  nxt_state;
  logic [8*Q_BYTES-1:0] q_data_ff;
  logic [2:0]  q_cnt_ff;
  logic        q_user_ff;
  logic        irq_take;
  logic        seg_call_take;
  logic        call_take;
  logic        push_take;
  logic        pop_take;
  logic        cur_internal;
  logic [15:0] cur_sp;
  logic [15:0] sp_dec;
  logic [15:0] sp_inc;

  assign busy          = (state_ff != SMR_IDLE);
  assign stk_busy_out  = busy;
  assign irq_take      = !busy && irq_entry_in;
  assign seg_call_take = !busy && !irq_entry_in && call_seg_in;
  assign call_take     = !busy && !irq_entry_in && !call_seg_in && call_in;
  assign push_take     = !busy && !irq_entry_in && !call_seg_in && !call_in && stk_req_in.push;
  assign pop_take      = !busy && !irq_entry_in && !call_seg_in && !call_in &&
                         !stk_req_in.push && stk_req_in.pop;

  assign cur_internal = q_user_ff ? core_mode_reg_ff[USER_STACK_BIT]
                                  : core_mode_reg_ff[SYS_STACK_BIT];
  assign cur_sp       = q_user_ff ? user_sp_ff : sys_sp_ff;
  // register-file stacks wrap inside the low byte
  assign sp_dec = cur_internal ? {cur_sp[15:8], cur_sp[7:0] - 8'h01} : cur_sp - 16'h0001;
  assign sp_inc = cur_internal ? {cur_sp[15:8], cur_sp[7:0] + 8'h01} : cur_sp + 16'h0001;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SMR_IDLE: begin
        if (irq_take || seg_call_take || call_take || push_take) begin
          nxt_state = SMR_PUSH;
        end else if (pop_take) begin
          nxt_state = SMR_POP;
        end
      end
      SMR_PUSH,
      SMR_POP: begin
        if (q_cnt_ff == Q_BYTE) begin
          nxt_state = SMR_IDLE;
        end
      end
      default: nxt_state = SMR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= SMR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // byte queue, low byte leaves first; page pointer never queued
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_data_ff <= '0;
      q_cnt_ff  <= 3'd0;
      q_user_ff <= 1'b0;
    end else if (irq_take) begin
      q_data_ff <= {2'b00, code_seg_in, flags_in, pc_in};
      q_cnt_ff  <= ext_mode_reg_two_ff[SEG_PUSH_EN_BIT] ? Q_IRQ_FULL : Q_IRQ_BASE;
      q_user_ff <= 1'b0;
    end else if (seg_call_take || call_take) begin
      q_data_ff <= {8'h00, 2'b00, code_seg_in, pc_in};
      q_cnt_ff  <= seg_call_take ? Q_SEG_CALL : Q_CALL;
      q_user_ff <= 1'b0;
    end else if (push_take || pop_take) begin
      q_data_ff <= {16'h0000, stk_req_in.data};
      q_cnt_ff  <= stk_req_in.word ? Q_WORD : Q_BYTE;
      q_user_ff <= stk_req_in.user;
    end else if (busy) begin
      q_data_ff <= {8'h00, q_data_ff[8*Q_BYTES-1:8]};
      q_cnt_ff  <= q_cnt_ff - 3'd1;
    end
  end

  // pointers: engine owns them while busy, software otherwise
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      user_sp_ff <= SP_RST;
      sys_sp_ff  <= SP_RST;
    end else if (busy) begin
      if (q_user_ff) begin
        user_sp_ff <= (state_ff == SMR_PUSH) ? sp_dec : sp_inc;
      end else begin
        sys_sp_ff  <= (state_ff == SMR_PUSH) ? sp_dec : sp_inc;
      end
    end else if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        USER_SP_HIGH_OFS: user_sp_ff[15:8] <= reg_req_in.wdata;
        USER_SP_LOW_OFS:  user_sp_ff[7:0]  <= reg_req_in.wdata;
        SYS_SP_HIGH_OFS:  sys_sp_ff[15:8]  <= reg_req_in.wdata;
        SYS_SP_LOW_OFS:   sys_sp_ff[7:0]   <= reg_req_in.wdata;
        default:          ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stk_wr_out         <= 1'b0;
      stk_rd_out         <= 1'b0;
      stk_addr_out       <= 16'h0000;
      stk_wr_data_out    <= 8'h00;
      stk_in_regfile_out <= 1'b0;
    end else begin
      stk_wr_out         <= (state_ff == SMR_PUSH);
      stk_rd_out         <= (state_ff == SMR_POP);
      stk_in_regfile_out <= cur_internal;
      if (state_ff == SMR_PUSH) begin
        stk_addr_out    <= sp_dec;
        stk_wr_data_out <= q_data_ff[7:0];
      end else if (state_ff == SMR_POP) begin
        stk_addr_out    <= cur_sp;
      end
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  page_low_zero_a: assert property (
    reg_req_in.rd && reg_req_in.addr == PAGE_POINTER_OFS |=> reg_rd_data_out[1:0] == 2'b00)
    else $error("page pointer low bits not zero");

  page_hold_a: assert property (
    !(reg_req_in.wr && reg_req_in.addr == PAGE_POINTER_OFS) |=> $stable(page_select_out))
    else $error("page changed without write");

  mode_write_a: assert property (
    reg_req_in.wr && reg_req_in.addr == CORE_MODE_OFS
      |=> core_mode_reg_ff == $past(reg_req_in.wdata))
    else $error("mode register not loaded");

  clk_undiv_a: assert property (
    (core_mode_reg_ff[7:2] == 6'h30) [*3] |-> core_clk_en_out)
    else $error("undivided clock enable missing");

  push_addr_a: assert property (
    state_ff == SMR_PUSH |=> stk_wr_out && stk_addr_out == (q_user_ff ? user_sp_ff : sys_sp_ff))
    else $error("push address not predecremented pointer");

  pop_read_a: assert property (
    pop_take |=> ##1 stk_rd_out && !stk_wr_out)
    else $error("pop did not read");

  irq_push_a: assert property (
    irq_take && ext_mode_reg_two_ff[SEG_PUSH_EN_BIT] |=> ##1 stk_wr_out [*4] ##1 !stk_wr_out)
    else $error("interrupt push count wrong");

  seg_call_a: assert property (
    seg_call_take |=> ##1 stk_wr_out [*3] ##1 !stk_wr_out)
    else $error("segment call push count wrong");

  bus_req_gate_a: assert property (
    !core_mode_reg_ff[BUS_REQ_ALLOW_BIT] |=> !bus_req_out)
    else $error("bus request passed while disabled");

  float_ctrl_a: assert property (
    core_mode_reg_ff[BUS_FLOAT_BIT] |=> ext_ctrl_oe_n_out == 3'b111)
    else $error("control lines driven while floated");

  rf_high_a: assert property (
    busy && cur_internal |=> $stable(q_user_ff ? user_sp_ff[15:8] : sys_sp_ff[15:8]))
    else $error("register-file stack touched high byte");

  irq_cov_c:  cover property (irq_take ##1 busy [*4]);
  pop_cov_c:  cover property (pop_take && stk_req_in.word);
  div8_cov_c: cover property (divider == 3'd7 && core_clk_en_out);

endmodule : smr_core_regs

`default_nettype wire

// ===== src/smr_pkg.sv
// Purpose: shared constants and carriers for the system page/mode/stack registers
// Assumes: 8-bit register port, one core clock
// Notes:   offsets are register-file addresses
package smr_pkg;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] PAGE_POINTER_OFS  = 8'hEA;
  localparam logic [7:0] CORE_MODE_OFS     = 8'hEB;
  localparam logic [7:0] USER_SP_HIGH_OFS  = 8'hEC;
  localparam logic [7:0] USER_SP_LOW_OFS   = 8'hED;
  localparam logic [7:0] SYS_SP_HIGH_OFS   = 8'hEE;
  localparam logic [7:0] SYS_SP_LOW_OFS    = 8'hEF;
  localparam logic [7:0] EXT_MODE_TWO_OFS  = 8'hF6;
  localparam logic [5:0] EXT_MODE_TWO_PAGE = 6'h15;
  localparam logic [3:0] TOP_GROUP         = 4'hF;

  // --------------------------------------------------------------------------
  // fields and reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] CORE_MODE_RST      = 8'hE0;
  localparam int         SYS_STACK_BIT      = 7;
  localparam int         USER_STACK_BIT     = 6;
  localparam int         OSC_HALVING_BIT    = 5;
  localparam int         DIVIDER_MSB        = 4;
  localparam int         DIVIDER_LSB        = 2;
  localparam int         BUS_REQ_ALLOW_BIT  = 1;
  localparam int         BUS_FLOAT_BIT      = 0;
  localparam int         PAGE_FIELD_LSB     = 2;
  localparam logic [7:0] PAGE_WR_MASK       = 8'hFC;
  localparam int         SEG_PUSH_EN_BIT    = 7;
  localparam int         DATA_PAGE_RELO_BIT = 5;
  localparam logic [7:0] EXT_MODE_TWO_MASK  = 8'hA0;
  localparam logic [7:0] EXT_MODE_TWO_RST   = 8'h00;
  localparam logic [15:0] SP_RST            = 16'h0000;

  // --------------------------------------------------------------------------
  // memory organisation
  // --------------------------------------------------------------------------
  localparam int SEG_W      = 6;
  localparam int PAGE_W     = 2;
  localparam int OFFSET_W   = 16;
  localparam int PHYS_W     = 22;
  localparam int Q_BYTES    = 4;
  localparam logic [2:0] Q_IRQ_FULL = 3'd4;
  localparam logic [2:0] Q_IRQ_BASE = 3'd3;
  localparam logic [2:0] Q_SEG_CALL = 3'd3;
  localparam logic [2:0] Q_CALL     = 3'd2;
  localparam logic [2:0] Q_WORD     = 3'd2;
  localparam logic [2:0] Q_BYTE     = 3'd1;

  typedef enum logic [1:0] {
    SMR_IDLE = 2'b00,
    SMR_PUSH = 2'b01,
    SMR_POP  = 2'b11
  } smr_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smr_reg_req_t;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic        user;
    logic        word;
    logic [15:0] data;
  } smr_stk_req_t;

endpackage : smr_pkg

// ===== verif/system_page_mode_stack_regs_tb.sv
// Purpose: self-checking bench for the page, mode and stack register block
// Assumes: 100 MHz core clock, reset held low for 12 cycles
// Notes:   table loop for register access, hand tests for stack, clock and bus
`timescale 1ns/10ps
`default_nettype none

module system_page_mode_stack_regs_tb;
  import smr_pkg::*;

  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  smr_reg_req_t reg_req_in = '0;
  smr_stk_req_t stk_req_in = '0;
  logic irq_entry_in = 1'b0, call_in = 1'b0, call_seg_in = 1'b0;
  logic [15:0] pc_in = 16'h1234;
  logic [7:0] flags_in = 8'h5A, ext_io_mode_in = 8'hF0, ext_io_oe_n_in = 8'h00;
  logic [5:0] code_seg_in = 6'h3F;
  logic bus_request_pin_in = 1'b0;
  logic [PHYS_W-1:0] mem_addr_in = '0;
  logic [7:0] rd_d, rd_q, ln_oe_n, ln_o, st_d;
  logic [15:0] st_a;
  logic [5:0] pg, seg;
  logic [1:0] mpg;
  logic [2:0] ctl_oe_n, ctl_o;
  logic pa, busy, swr, srd, regf, cen, bus_request_pin, mres;
  logic [15:0] wa[$];
  logic [7:0] wd[$];
  logic [15:0] ra[$];
  logic last_pg;
  int fail_count = 0, compares = 0, cyc = 0, n;
  localparam logic [23:0] ROWS [10] = '{24'hEAFFFC, 24'hEC5A5A, 24'hEDA5A5, 24'hEE3C3C,
    24'hEFC3C3, 24'hEB1F1F, 24'hEBE0E0, 24'hE07700, 24'hEA5454, 24'hF6FFA0};

  always #5 clk_in = ~clk_in;

  smr_core_regs #(.INT_SEG_BYTES(17'h08000)) DUT (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_req_in(reg_req_in), .reg_rd_data_out(rd_q),
    .page_select_out(pg), .paged_access_out(pa), .stk_req_in(stk_req_in),
    .irq_entry_in(irq_entry_in), .call_in(call_in), .call_seg_in(call_seg_in),
    .pc_in(pc_in), .flags_in(flags_in), .code_seg_in(code_seg_in), .stk_busy_out(busy),
    .stk_wr_out(swr), .stk_rd_out(srd), .stk_addr_out(st_a), .stk_wr_data_out(st_d),
    .stk_in_regfile_out(regf), .core_clk_en_out(cen), .bus_request_pin_in(bus_request_pin_in),
    .bus_req_out(bus_request_pin), .ext_line_in(8'hA5), .ext_io_mode_in(ext_io_mode_in),
    .ext_io_oe_n_in(ext_io_oe_n_in), .ext_line_out(ln_o), .ext_line_oe_n_out(ln_oe_n),
    .ext_ctrl_in(3'h5), .ext_ctrl_out(ctl_o), .ext_ctrl_oe_n_out(ctl_oe_n),
    .mem_addr_in(mem_addr_in), .mem_segment_out(seg), .mem_page_out(mpg),
    .mem_reserved_out(mres));

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  always @(negedge clk_in) begin
    if (swr === 1'b1) begin
      wa.push_back(st_a);
      wd.push_back(st_d);
    end
    if (srd === 1'b1) ra.push_back(st_a);
  end

  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) reg_req_in <= {1'b1, 1'b0, a, d};
    @(posedge clk_in) reg_req_in <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in) reg_req_in <= {1'b0, 1'b1, a, 8'h00};
    @(negedge clk_in) last_pg = pa;
    @(posedge clk_in) reg_req_in <= '0;
    @(posedge clk_in) #1 d = rd_q;
  endtask : rd

  // k = {irq, call_seg, call, push, pop, user, word}
  task automatic stk(input logic [6:0] k, input logic [15:0] d);
    wa.delete();
    wd.delete();
    ra.delete();
    @(posedge clk_in) {irq_entry_in, call_seg_in, call_in} <= k[6:4];
    stk_req_in <= {k[3:0], d};
    @(posedge clk_in) {irq_entry_in, call_seg_in, call_in} <= 3'b000;
    stk_req_in <= '0;
    #1 chk("engine busy", busy, 1'b1);
    repeat (8) @(posedge clk_in);
  endtask : stk

  task automatic bytes_chk(input int cnt, input logic [31:0] exp);
    chk("push count", 16'(wd.size()), 16'(cnt));
    for (int i = 0; i < cnt && i < wd.size(); i++) chk("push byte", wd[i], exp[31-8*i -: 8]);
  endtask : bytes_chk

  task automatic per(output int p);
    p = 0;
    do @(negedge clk_in); while (cen !== 1'b1 && ++p < 20);
    p = 0;
    do begin @(negedge clk_in); p++; end while (cen !== 1'b1 && p < 20);
  endtask : per

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(CORE_MODE_OFS, rd_d);
    chk("mode reset", rd_d, 16'h00E0);
    chk("page reset", pg, 16'h0000);
    foreach (ROWS[i]) begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], rd_d);
      chk("reg row", rd_d, ROWS[i][7:0]);
    end
    chk("page field", pg, 16'h0015);
    chk("paged access", last_pg, 1'b1);
    // system stack word push and pop in the register file
    wr(SYS_SP_HIGH_OFS, 8'h00);
    wr(SYS_SP_LOW_OFS, 8'h80);
    stk(7'b0001001, 16'hABCD);
    bytes_chk(2, 32'hCDAB0000);
    chk("push addr", wa[0], 16'h007F);
    chk("regfile stack", regf, 1'b1);
    stk(7'b0000101, 16'h0000);
    chk("pop no write", 16'(wa.size()), 16'h0000);
    chk("pop addr", ra[0], 16'h007E);
    rd(SYS_SP_LOW_OFS, rd_d);
    chk("sp after pop", rd_d, 16'h0080);
    // user stack byte push
    wr(USER_SP_HIGH_OFS, 8'h00);
    wr(USER_SP_LOW_OFS, 8'h10);
    stk(7'b0001010, 16'h0055);
    bytes_chk(1, 32'h55000000);
    chk("user addr", wa[0], 16'h000F);
    // automatic pushes, segment stacking on then off
    stk(7'b1000000, 16'h0000);
    bytes_chk(4, 32'h34125A3F);
    wr(EXT_MODE_TWO_OFS, 8'h00);
    stk(7'b1000000, 16'h0000);
    bytes_chk(3, 32'h34125A00);
    stk(7'b0010000, 16'h0000);
    bytes_chk(2, 32'h34120000);
    stk(7'b0100000, 16'h0000);
    bytes_chk(3, 32'h34123F00);
    // register-file stack keeps its high byte; pointer stays in the low groups
    wr(SYS_SP_HIGH_OFS, 8'h12);
    wr(SYS_SP_LOW_OFS, 8'h40);
    stk(7'b0001000, 16'h0011);
    rd(SYS_SP_LOW_OFS, rd_d);
    chk("rf low", rd_d, 16'h003F);
    rd(SYS_SP_HIGH_OFS, rd_d);
    chk("rf high", rd_d, 16'h0012);
    // memory system stack borrows into the high byte
    wr(CORE_MODE_OFS, 8'h60);
    wr(SYS_SP_LOW_OFS, 8'h00);
    stk(7'b0001000, 16'h0022);
    chk("mem stack addr", wa[0], 16'h11FF);
    chk("mem stack sel", regf, 1'b0);
    // clock division
    per(n);
    chk("div reset", 16'(n), 16'h0002);
    wr(CORE_MODE_OFS, 8'hC8);
    repeat (10) @(posedge clk_in);
    per(n);
    chk("div prs2", 16'(n), 16'h0003);
    wr(CORE_MODE_OFS, 8'hFC);
    repeat (20) @(posedge clk_in);
    per(n);
    chk("div max", 16'(n), 16'h0010);
    // bus request gating
    @(posedge clk_in) bus_request_pin_in <= 1'b1;
    wr(CORE_MODE_OFS, 8'hC0);
    repeat (5) @(posedge clk_in);
    #1 chk("bus_request_pin off", bus_request_pin, 1'b0);
    wr(CORE_MODE_OFS, 8'hC2);
    repeat (5) @(posedge clk_in);
    #1 chk("bus_request_pin on", bus_request_pin, 1'b1);
    // float keeps general I/O lines
    wr(CORE_MODE_OFS, 8'hC1);
    repeat (3) @(posedge clk_in);
    #1 chk("ctrl float", ctl_oe_n, 3'h7);
    chk("line float", ln_oe_n, 8'h0F);
    chk("line data", ln_o, 8'hA5);
    chk("ctrl data", ctl_o, 3'h5);
    wr(CORE_MODE_OFS, 8'hC0);
    repeat (3) @(posedge clk_in);
    #1 chk("ctrl drive", ctl_oe_n, 3'h0);
    // segment, page and reserved decode
    @(posedge clk_in) mem_addr_in <= {6'h2A, 16'h9ABC};
    repeat (2) @(posedge clk_in);
    #1 chk("seg page res", {seg, mpg, mres}, {7'h0, 6'h2A, 2'h2, 1'b1});
    @(posedge clk_in) mem_addr_in <= {6'h01, 16'h1234};
    repeat (2) @(posedge clk_in);
    #1 chk("seg page ok", {seg, mpg, mres}, {7'h0, 6'h01, 2'h0, 1'b0});
    chk("page kept", pg, 16'h0015);
    give_verdict();
  end
endmodule : system_page_mode_stack_regs_tb

`default_nettype wire
